// >>> rsp_pkg.sv
// package: constants shared by both ends of the register serial port
package rsp_pkg;
  localparam logic [6:0] DEV_ADDR      = 7'h5B;
  localparam int         CMD_ADDR_BITS = 6;
  localparam logic [5:0] LAST_REG      = 6'h03;
  localparam int         NUM_REGS      = 4;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam int         CLK_SYS_MHZ   = 125;
  localparam int         LINK_KHZ      = 400;
  localparam int         HALF_BIT_CYC  = (CLK_SYS_MHZ * 1000) / (LINK_KHZ * 2);
  localparam int         HALF_W        = 9;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

// >>> rsp_link_if.sv
// interface: the two-wire serial link between master and slave
`timescale 1ns/1ns
interface rsp_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl_oe_s;
  logic scl;
  logic sda;
  assign scl = ~((scl_oe & ~scl_o) | (scl_oe_s));
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
                  input scl, input sda);
  modport slave  (output sda_s_o, output sda_s_oe, output scl_oe_s,
                  input scl, input sda);
endinterface

// >>> rsp_sync.sv
// two-stage synchroniser with edge detection on the settled level
`timescale 1ns/1ns
module rsp_sync (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic d_i,
  output logic      q_o,
  output logic      rise_o,
  output logic      fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } rsp_sync_type;
  rsp_sync_type st_r;
  rsp_sync_type st_nxt;
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end
  // idle bus is high, so reset to one avoids a false edge
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= 3'b111;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q_o    = st_r.s2;
  assign rise_o = st_r.s2 & ~st_r.s3;
  assign fall_o = ~st_r.s2 & st_r.s3;
endmodule

// >>> rsp_slave.sv
// slave end: serial register port with four byte registers
//
// Operation
// - slave only, never drives or stretches clock
// - master starts only on idle bus
// - one bit per clock, data steady high
// - data falling while clock high is start
// - data rising while clock high is stop
// - busy from start until stop
// - fixed seven bit address 0x5B
// - compare first seven bits after start
// - eighth address bit gives direction
// - ninth clock is acknowledge, bytes unlimited
// - acknowledger holds data low through clock high
// - acknowledge every received byte except rejects
// - master acknowledges all but last read
// - on master nack release data line
// - command low six bits select register
// - single write: address, command, data, stop
// - nack write command to missing register
// - read via repeated start, eight bits msb first
// - nack read command to missing register
// - registers 0x00 to 0x03 exist only
`timescale 1ns/1ns
module rsp_slave (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  rsp_link_if.slave       link,
  input  wire logic [7:0] status_i,
  output logic [7:0]      ctrl_o,
  output logic [7:0]      out_ctrl_o,
  output logic [7:0]      vout_o,
  output logic            busy_o,
  output logic            wr_strobe_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD  = 3'b010,
    ST_WDAT = 3'b011,
    ST_RDAT = 3'b100,
    ST_SKIP = 3'b101
  } rsp_state_type;

  typedef struct packed {
    rsp_state_type   state;
    logic [3:0]      bitcnt;
    logic [7:0]      shift;
    logic            ack_phase;
    logic            ack_drive;
    logic            rd_mode;
    logic            mst_ack;
    logic            tx_drive;
    logic [5:0]      reg_addr;
    logic [3:0][7:0] regs;
    logic            busy;
    logic            wr_pulse;
  } rsp_slave_type;

  rsp_slave_type st_r;
  rsp_slave_type st_nxt;
  logic          scl_q;
  logic          scl_rise;
  logic          scl_fall;
  logic          sda_q;
  logic          sda_rise;
  logic          sda_fall;
  logic          start_det;
  logic          stop_det;
  logic          reg_ok;

  ////////////////////////////////////////////////////////////////////////////
  rsp_sync u_scl (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .d_i       (link.scl),
    .q_o       (scl_q),
    .rise_o    (scl_rise),
    .fall_o    (scl_fall)
  );
  rsp_sync u_sda (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .d_i       (link.sda),
    .q_o       (sda_q),
    .rise_o    (sda_rise),
    .fall_o    (sda_fall)
  );

  assign start_det = sda_fall & scl_q;
  assign stop_det  = sda_rise & scl_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt          = st_r;
    st_nxt.wr_pulse = 1'b0;
    reg_ok          = 1'b0;
    if (start_det) begin
      st_nxt.state     = ST_ADDR;
      st_nxt.bitcnt    = 4'h0;
      st_nxt.ack_phase = 1'b0;
      st_nxt.ack_drive = 1'b0;
      st_nxt.tx_drive  = 1'b0;
      st_nxt.busy      = 1'b1;
    end else if (stop_det) begin
      st_nxt.state     = ST_IDLE;
      st_nxt.ack_drive = 1'b0;
      st_nxt.tx_drive  = 1'b0;
      st_nxt.busy      = 1'b0;
    end else if (st_r.state != ST_IDLE && st_r.state != ST_SKIP) begin
      if (scl_rise) begin
        if (st_r.ack_phase) begin
          st_nxt.mst_ack = ~sda_q;
        end else if (st_r.state != ST_RDAT) begin
          st_nxt.shift  = {st_r.shift[6:0], sda_q};
        end
        if (!st_r.ack_phase) begin
          st_nxt.bitcnt = st_r.bitcnt + 4'h1;
        end
      end
      if (scl_fall) begin
        if (!st_r.ack_phase && st_r.bitcnt == rsp_pkg::BITS_PER_BYTE) begin
          // ninth clock: decide acknowledge on the completed byte
          st_nxt.ack_phase = 1'b1;
          st_nxt.bitcnt    = 4'h0;
          st_nxt.tx_drive  = 1'b0;
          case (st_r.state)
            ST_ADDR: begin
              if (st_r.shift[7:1] == rsp_pkg::DEV_ADDR) begin
                st_nxt.ack_drive = 1'b1;
                st_nxt.rd_mode   = st_r.shift[0];
              end else begin
                st_nxt.state = ST_SKIP;
              end
            end
            ST_CMD: begin
              reg_ok = st_r.shift[5:0] <= rsp_pkg::LAST_REG;
              if (reg_ok) begin
                st_nxt.reg_addr  = st_r.shift[rsp_pkg::CMD_ADDR_BITS-1:0];
                st_nxt.ack_drive = 1'b1;
              end else begin
                st_nxt.state = ST_SKIP;
              end
            end
            ST_WDAT: begin
              st_nxt.regs[st_r.reg_addr[1:0]] = st_r.shift;
              st_nxt.wr_pulse  = 1'b1;
              st_nxt.ack_drive = 1'b1;
            end
            ST_RDAT: begin
              st_nxt.ack_drive = 1'b0; // master acknowledges here
            end
            default: begin
              st_nxt.state = ST_SKIP;
            end
          endcase
        end else if (st_r.ack_phase) begin
          // end of acknowledge clock: release line, pick next byte
          st_nxt.ack_phase = 1'b0;
          st_nxt.ack_drive = 1'b0;
          case (st_r.state)
            ST_ADDR: begin
              if (st_r.rd_mode) begin
                st_nxt.state    = ST_RDAT;
                st_nxt.shift    = (st_r.reg_addr[5:0] <= rsp_pkg::LAST_REG) ?
                                  st_r.regs[st_r.reg_addr[1:0]] : rsp_pkg::REG_RESET;
                st_nxt.tx_drive = 1'b1;
              end else begin
                st_nxt.state = ST_CMD;
              end
            end
            ST_CMD: begin
              st_nxt.state = ST_WDAT;
            end
            ST_RDAT: begin
              if (st_r.mst_ack) begin
                // repeat the same register; byte count is unlimited
                st_nxt.shift    = st_r.regs[st_r.reg_addr[1:0]];
                st_nxt.tx_drive = 1'b1;
              end else begin
                st_nxt.state    = ST_SKIP;
                st_nxt.tx_drive = 1'b0;
              end
            end
            default: begin
              st_nxt.state = st_r.state;
            end
          endcase
        end else if (st_r.state == ST_RDAT && st_r.bitcnt != 4'h0) begin
          st_nxt.shift = {st_r.shift[6:0], 1'b1};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers clear with the link state on nrst_i; start and stop leave them
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // open drain: drive only a low, never touch the clock
  assign link.scl_oe_s = 1'b0;
  assign link.sda_s_o  = 1'b0;
  assign link.sda_s_oe = st_r.ack_drive | (st_r.tx_drive & ~st_r.shift[7]);
  assign ctrl_o        = st_r.regs[0];
  assign out_ctrl_o    = st_r.regs[1];
  assign vout_o        = st_r.regs[2];
  assign busy_o        = st_r.busy;
  assign wr_strobe_o   = st_r.wr_pulse;
  logic unused_status;
  assign unused_status = ^status_i;
endmodule

// >>> rsp_master.sv
// master end: issues single register writes and reads on the serial link
`timescale 1ns/1ns
module rsp_master (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  rsp_link_if.master      link,
  input  wire logic       req_i,
  input  wire logic       rd_i,
  input  wire logic [5:0] reg_i,
  input  wire logic [7:0] wdata_i,
  output logic            ready_o,
  output logic            done_o,
  output logic            nack_o,
  output logic [7:0]      rdata_o
);
  typedef enum logic [2:0] {
    MS_IDLE  = 3'b000,
    MS_START = 3'b001,
    MS_BYTE  = 3'b010,
    MS_ACK   = 3'b011,
    MS_STOP  = 3'b100,
    MS_DONE  = 3'b101
  } rsp_mst_state_type;

  typedef struct packed {
    rsp_mst_state_type state;
    logic [8:0]        tmr;
    logic [1:0]        phase;
    logic [3:0]        bitcnt;
    logic [1:0]        bytenum;
    logic [7:0]        shift;
    logic              scl;
    logic              sda;
    logic              rd;
    logic              resent;
    logic [5:0]        reg_a;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic              nack;
    logic              done;
  } rsp_master_type;

  rsp_master_type st_r;
  rsp_master_type st_nxt;
  logic           sda_s1;
  logic           sda_q;
  logic           tick;
  logic           last_byte;

  // sample the open-drain data line through two flops
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_s1 <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      sda_s1 <= link.sda;
      sda_q  <= sda_s1;
    end
  end

  assign tick      = st_r.tmr == rsp_pkg::HALF_W'(rsp_pkg::HALF_BIT_CYC - 1);
  assign last_byte = st_r.rd ? (st_r.bytenum == 2'h3) : (st_r.bytenum == 2'h2);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    st_nxt.tmr  = tick ? '0 : st_r.tmr + 9'h001;
    case (st_r.state)
      MS_IDLE: begin
        st_nxt.tmr = '0;
        if (req_i) begin
          st_nxt.state   = MS_START;
          st_nxt.rd      = rd_i;
          st_nxt.reg_a   = reg_i;
          st_nxt.wdata   = wdata_i;
          st_nxt.bytenum = 2'h0;
          st_nxt.resent  = 1'b0;
          st_nxt.nack    = 1'b0;
          st_nxt.phase   = 2'h0;
        end
      end
      MS_START: begin
        if (tick) begin
          st_nxt.phase = st_r.phase + 2'h1;
          case (st_r.phase)
            2'h0: begin st_nxt.sda = 1'b1; st_nxt.scl = 1'b1; end
            2'h1: begin st_nxt.sda = 1'b0; end
            default: begin
              st_nxt.scl    = 1'b0;
              st_nxt.state  = MS_BYTE;
              st_nxt.bitcnt = 4'h0;
              st_nxt.phase  = 2'h0;
              st_nxt.shift  = {rsp_pkg::DEV_ADDR, st_r.resent};
            end
          endcase
        end
      end
      MS_BYTE, MS_ACK: begin
        if (tick) begin
          st_nxt.phase = st_r.phase + 2'h1;
          case (st_r.phase)
            2'h0: begin
              // data changes only while clock is low
              if (st_r.state == MS_ACK) begin
                st_nxt.sda = st_r.bytenum == 2'h3 ? 1'b1 : 1'b1;
              end else if (st_r.bytenum == 2'h3) begin
                st_nxt.sda = 1'b1;
              end else begin
                st_nxt.sda = st_r.shift[7];
              end
            end
            2'h1: begin
              st_nxt.scl = 1'b1;
            end
            2'h2: begin
              if (st_r.state == MS_ACK && st_r.bytenum != 2'h3) begin
                st_nxt.nack = st_r.nack | sda_q;
              end else if (st_r.state == MS_BYTE && st_r.bytenum == 2'h3) begin
                // the acknowledge slot is not a data bit
                st_nxt.rdata = {st_r.rdata[6:0], sda_q};
              end
            end
            default: begin
              st_nxt.scl   = 1'b0;
              st_nxt.phase = 2'h0;
              if (st_r.state == MS_BYTE) begin
                st_nxt.shift  = {st_r.shift[6:0], 1'b0};
                st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                if (st_r.bitcnt == 4'h7) begin
                  st_nxt.state = MS_ACK;
                end
              end else begin
                st_nxt.bitcnt  = 4'h0;
                st_nxt.bytenum = st_r.bytenum + 2'h1;
                if (st_r.nack || last_byte) begin
                  st_nxt.state = MS_STOP;
                end else if (st_r.bytenum == 2'h1 && st_r.rd) begin
                  st_nxt.state  = MS_START;
                  st_nxt.resent = 1'b1;
                  st_nxt.phase  = 2'h0;
                end else begin
                  st_nxt.state = MS_BYTE;
                  st_nxt.shift = st_r.bytenum == 2'h0 ? {2'b00, st_r.reg_a} : st_r.wdata;
                end
              end
            end
          endcase
        end
      end
      MS_STOP: begin
        if (tick) begin
          st_nxt.phase = st_r.phase + 2'h1;
          case (st_r.phase)
            2'h0: begin st_nxt.sda = 1'b0; end
            2'h1: begin st_nxt.scl = 1'b1; end
            default: begin
              st_nxt.sda   = 1'b1;
              st_nxt.state = MS_DONE;
            end
          endcase
        end
      end
      MS_DONE: begin
        st_nxt.done  = 1'b1;
        st_nxt.state = MS_IDLE;
      end
      default: begin
        st_nxt.state = MS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r     <= '0;
      st_r.scl <= 1'b1;
      st_r.sda <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // master owns the clock; pulls lines only low
  assign link.scl_o    = 1'b0;
  assign link.scl_oe   = ~st_r.scl;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = ~st_r.sda;
  assign ready_o       = st_r.state == MS_IDLE;
  assign done_o        = st_r.done;
  assign nack_o        = st_r.nack;
  assign rdata_o       = st_r.rdata;
endmodule

// >>> rsp_checker.sv
// checker: assertions on the two-wire link between master and slave
`timescale 1ns/1ns
module rsp_checker (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl_oe_s
);
  typedef struct packed {
    logic       sc;
    logic       sd;
    logic       nk;
    logic       rw;
    logic [1:0] byt;
    logic [3:0] pos;
    logic [7:0] sh;
  } rsp_chk_type;
  rsp_chk_type st_r;
  rsp_chk_type st_nxt;
  logic        hi;
  logic        ack;
  logic        pull;
  assign hi   = st_r.sc & scl;
  assign ack  = hi & (st_r.pos == 4'h9);
  assign pull = sda_s_oe & ~sda_s_o;
  ////////////////////////////////////////
  // pos counts clock rises; 9 is the acknowledge slot, byt saturates
  always_comb begin
    st_nxt    = st_r;
    st_nxt.sc = scl;
    st_nxt.sd = sda;
    if (ack & st_r.rw & (st_r.byt != 2'h0) & sda) st_nxt.nk = 1'b1;
    if (hi & (st_r.sd != sda)) begin
      st_nxt.nk  = 1'b0;
      st_nxt.pos = 4'h0;
      st_nxt.byt = 2'h0;
    end else if (~st_r.sc & scl) begin
      st_nxt.pos = (st_r.pos == 4'h9) ? 4'h1 : st_r.pos + 4'h1;
      if (st_r.pos == 4'h9 && st_r.byt != 2'h3) st_nxt.byt = st_r.byt + 2'h1;
      if (st_r.pos != 4'h8) st_nxt.sh = {st_r.sh[6:0], sda};
      if (st_r.pos == 4'h7 && st_r.byt == 2'h0) st_nxt.rw = sda;
    end
  end
  // idle lines are high: no false clock rise at reset release
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r    <= '0;
      st_r.sc <= 1'b1;
      st_r.sd <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  AST_NO_SLAVE_CLK: assert property (scl_oe_s == 1'b0)
    else $error("slave pulled the clock line");
  AST_SDA_STEADY: assert property (hi |-> $stable(pull))
    else $error("slave changed data while clock high");
  AST_ADDR_SILENT: assert property (hi && st_r.byt == 2'h0 && st_r.pos != 4'h9 |-> !pull)
    else $error("slave drove data during address bits");
  AST_ADDR_ACK: assert property (ack && st_r.byt == 2'h0 && st_r.sh[7:1] == rsp_pkg::DEV_ADDR |-> pull)
    else $error("own address not acknowledged");
  AST_CMD_ACK: assert property (ack && st_r.byt == 2'h1 && !st_r.rw |-> pull == (st_r.sh[5:0] <= rsp_pkg::LAST_REG))
    else $error("command acknowledge wrong");
  AST_DATA_ACK: assert property (ack && st_r.byt[1] && !st_r.rw |-> pull)
    else $error("write data not acknowledged");
  AST_READ_RELEASE: assert property (ack && st_r.byt != 2'h0 && st_r.rw |-> !pull)
    else $error("slave held data in read acknowledge");
  AST_NACK_HOLD: assert property (st_r.nk |=> !pull)
    else $error("slave drove data after master nack");
  AST_WR_SILENT: assert property (hi && st_r.byt != 2'h0 && !st_r.rw && st_r.pos != 4'h9 |-> !pull)
    else $error("slave drove data in write bits");
  COV_WRITE: cover property (ack && st_r.byt == 2'h2 && !st_r.rw && !sda);
  COV_READ_NACK: cover property (st_r.nk);
  COV_CMD_REJECT: cover property (ack && st_r.byt == 2'h1 && !st_r.rw && sda);
endmodule

// >>> rsp_slave_test.sv
// testbench: master and slave joined over the link, checked end to end
`timescale 1ns/1ns
module rsp_slave_test;
  typedef struct packed {
    logic       rd;
    logic [5:0] ra;
    logic [7:0] wd;
    logic       nk;
    logic [7:0] rdv;
  } rsp_row_type;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        req_i     = 1'b0;
  logic        rd_i      = 1'b0;
  logic [5:0]  reg_i     = 6'h00;
  logic [7:0]  wdata_i   = 8'h00;
  logic        ready_o, done_o, nack_o, busy_o, wr_strobe_o;
  logic [7:0]  rdata_o, ctrl_o, out_ctrl_o, vout_o;
  logic [7:0]  model [4] = '{default: 8'h00};
  int          failures  = 0;
  int          checked   = 0;
  int          strobes   = 0;
  int          s0;
  rsp_row_type rows [4]  = '{'{1'b0, 6'h02, 8'hA5, 1'b0, 8'h00},
                             '{1'b1, 6'h02, 8'h00, 1'b0, 8'hA5},
                             '{1'b0, 6'h3F, 8'h3C, 1'b1, 8'h00},
                             '{1'b1, 6'h04, 8'h00, 1'b1, 8'h00}};
  rsp_link_if rsp_link_if_i ();
  rsp_master rsp_master_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(rsp_link_if_i),
    .req_i(req_i), .rd_i(rd_i), .reg_i(reg_i), .wdata_i(wdata_i), .ready_o(ready_o),
    .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
  rsp_slave rsp_slave_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(rsp_link_if_i),
    .status_i(8'h00), .ctrl_o(ctrl_o), .out_ctrl_o(out_ctrl_o), .vout_o(vout_o),
    .busy_o(busy_o), .wr_strobe_o(wr_strobe_o));
  rsp_checker rsp_checker_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl(rsp_link_if_i.scl),
    .sda(rsp_link_if_i.sda), .sda_s_o(rsp_link_if_i.sda_s_o),
    .sda_s_oe(rsp_link_if_i.sda_s_oe), .scl_oe_s(rsp_link_if_i.scl_oe_s));
  ////////////////////////////////////////
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (wr_strobe_o === 1'b1) strobes++;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic check_regs();
    check(ctrl_o, model[0]);
    check(out_ctrl_o, model[1]);
    check(vout_o, model[2]);
  endtask
  // request held exactly one edge; master only takes it while ready
  task automatic launch(input rsp_row_type r);
    int n = 0;
    while (ready_o !== 1'b1 && n < 40000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 40000) failures++;
    req_i   <= 1'b1;
    rd_i    <= r.rd;
    reg_i   <= r.ra;
    wdata_i <= r.wd;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
  endtask
  task automatic xfer(input rsp_row_type r);
    int n = 0;
    launch(r);
    while (done_o !== 1'b1 && n < 40000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 40000) failures++;
    // slave sees the stop through its synchroniser a few edges after done
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic conclude();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #760000;
    failures++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    check({rsp_link_if_i.scl, rsp_link_if_i.sda, ready_o, busy_o}, 8'h0E);
    check_regs();
    for (int i = 0; i < 4; i++) begin
      s0 = strobes;
      xfer(rows[i]);
      if (!rows[i].rd && !rows[i].nk) model[rows[i].ra[1:0]] = rows[i].wd;
      check(nack_o, rows[i].nk);
      check(8'(strobes - s0), (rows[i].rd | rows[i].nk) ? 8'h00 : 8'h01);
      check(busy_o, 1'b0);
      if (rows[i].rd && !rows[i].nk) check(rdata_o, rows[i].rdv);
      check_regs();
    end
    // abort mid-address by reset, then a clean write must still land
    launch('{1'b0, 6'h01, 8'hFF, 1'b0, 8'h00});
    repeat (4000) @(posedge clk_sys_i);
    check(busy_o, 1'b1);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    model = '{default: 8'h00};
    check({rsp_link_if_i.scl, rsp_link_if_i.sda, ready_o, busy_o}, 8'h0E);
    check_regs();
    nrst_i <= 1'b1;
    xfer('{1'b0, 6'h01, 8'h5A, 1'b0, 8'h00});
    model[1] = 8'h5A;
    check(nack_o, 1'b0);
    check_regs();
    conclude();
  end
endmodule
